// ===== tgc_pkg.sv
// ==========================================================================
// Shared constants and carriers
package tgc_pkg;

  // ========================================================================
  // Widths
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int SAMP_W = 10;
  localparam int GAIN_W = 8;

  // ========================================================================
  // Register indices (byte address is four times the index)
  localparam logic [5:0] IDX_GAIN = 6'h0B;
  localparam logic [5:0] IDX_UPD  = 6'h0C;
  localparam logic [5:0] IDX_FMT  = 6'h0D;
  localparam logic [5:0] IDX_MODE = 6'h0E;
  localparam logic [5:0] IDX_STAT = 6'h10;

  // ========================================================================
  // Reset values and writable masks
  localparam logic [7:0] GAIN_RST  = 8'hFF;
  localparam logic [7:0] UPD_RST   = 8'h00;
  localparam logic [7:0] FMT_RST   = 8'h00;
  localparam logic [7:0] MODE_RST  = 8'h10;
  localparam logic [7:0] UPD_MASK  = 8'h50;
  localparam logic [7:0] FMT_MASK  = 8'hE3;
  localparam logic [7:0] MODE_MASK = 8'h35;

  // ========================================================================
  // Field positions
  localparam int UPD_SYNC_BIT   = 6;
  localparam int UPD_FAST_BIT   = 4;
  localparam int FMT_TX2C_BIT   = 7;
  localparam int FMT_RX2C_BIT   = 6;
  localparam int FMT_INV_BIT    = 5;
  localparam int MODE_LOOP_BIT  = 5;
  localparam int MODE_FULL_BIT  = 4;
  localparam int MODE_W10_BIT   = 2;
  localparam int MODE_CLONE_BIT = 0;
  localparam int STAT_OVF_BIT   = 0;

  // ========================================================================
  // Codes
  localparam logic [1:0] INTERP_2X   = 2'h1;
  localparam logic [1:0] INTERP_4X   = 2'h2;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  typedef enum logic [1:0] {
    FULL_DUPLEX_MODE  = 2'h0,
    HALF_DUPLEX_10BIT = 2'h1,
    HALF_DUPLEX_20BIT = 2'h2,
    CLONE_MODE        = 2'h3
  } tgc_mode_type;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ACK  = 2'b10
  } tgc_bus_type;

  // ========================================================================
  // Carriers
  typedef struct packed {
    logic [7:0] gain;
    logic [7:0] upd;
    logic [7:0] fmt;
    logic [7:0] mode;
  } tgc_cfg_type;

  typedef struct packed {
    tgc_bus_type             bus;
    logic [DATA_W-1:0]       rdata;
    logic [1:0]              resp;
    tgc_cfg_type             cfg;
    logic [GAIN_W-1:0]       target;
    logic [GAIN_W-1:0]       applied;
    logic                    ovf;
    logic [2:0]              clk_sync;
    logic [2:0]              pd_sync;
    logic [SAMP_W-1:0]       dat_s1;
    logic [SAMP_W-1:0]       dat_s2;
    logic [1:0][SAMP_W-1:0]  mem;
    logic                    wr_ptr;
    logic                    rd_ptr;
    logic [1:0]              count;
    logic [SAMP_W-1:0]       hold;
    logic [1:0]              rep;
    logic [SAMP_W-1:0]       out_data;
    logic                    out_valid;
    logic [SAMP_W-1:0]       rx_data;
    logic                    rx_valid;
    tgc_mode_type            mode;
  } tgc_state_type;

endpackage

// ===== tgc_regs.sv
// Implementation choice: register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// R1 - Transmit gain code is 8-bit unsigned, bit 0 least significant.
// R2 - Gain spans 20 dB in 0.1 dB steps, shared by both channels.
// R3 - Gain register resets to all ones, maximum gain.
// R4 - Code zero gives -20 dB scaling, all ones gives 0 dB.
// R5 - Without gain sync, a new gain applies right after the write.
// R6 - With gain sync set, gain updates only on power-down pin falling edge.
// R7 - Fast settle bit jumps gain; otherwise gain ramps smoothly.
// R8 - Transmit words are unsigned by default, two's complement when bit 7 set.
// R9 - Receive words are unsigned by default, two's complement when bit 6 set.
// R10 - Transmit data sampled on output clock rising edge, falling when bit 5 set.
// R11 - Interpolation field: 00 bypass, 01 two times, 10 four times.
// R12 - Loopback sends transmit path result, interpolated, out on receive bus.
// R13 - Controller must select full duplex whenever it enables loopback.
// R14 - Duplex bit high full, low half; with width bit gives three modes.
// R15 - Duplex bit is ignored while clone mode is on.
// R16 - Width bit high selects 10-bit interleaved, low selects 20-bit.
module tgc_regs
  import tgc_pkg::*;
(
  input  wire logic              REF_CLK,
  input  wire logic              RST_B,
  input  wire logic [ADDR_W-1:0] AVS_ADDRESS,
  input  wire logic              AVS_READ,
  input  wire logic              AVS_WRITE,
  input  wire logic [DATA_W-1:0] AVS_WRITEDATA,
  input  wire logic [3:0]        AVS_BYTEENABLE,
  output logic      [DATA_W-1:0] AVS_READDATA,
  output logic      [1:0]        AVS_RESPONSE,
  output logic                   AVS_WAITREQUEST,
  input  wire logic              OUTPUT_CLOCK_PIN,
  input  wire logic              TX_POWERDOWN_PIN,
  input  wire logic [SAMP_W-1:0] TX_BUS_IN,
  input  wire logic [SAMP_W-1:0] RX_ADC_IN,
  input  wire logic              RX_ADC_VALID,
  output logic      [SAMP_W-1:0] TX_PATH_DATA,
  output logic                   TX_PATH_VALID,
  input  wire logic              TX_PATH_READY,
  output logic      [SAMP_W-1:0] RX_BUS_OUT,
  output logic                   RX_BUS_VALID,
  output logic      [GAIN_W-1:0] TX_GAIN_AMP,
  output logic                   GAIN_FAST_SETTLE,
  output logic      [1:0]        INTERP_RATE,
  output logic      [1:0]        IF_MODE,
  output logic                   LOOPBACK_ON
);

  // ========================================================================
  // State and decode
  tgc_state_type     s;
  tgc_state_type     n;
  logic [5:0]        idx;
  logic              hit;
  logic [DATA_W-1:0] rd_val;
  logic              wr_en;
  logic              clk_rise;
  logic              clk_fall;
  logic              push;
  logic              push_ok;
  logic              pop;
  logic              full;
  logic              pd_fall;
  logic              dn_ready;
  logic              loop;
  logic [1:0]        rate_m1;
  logic [SAMP_W-1:0] word;

  assign idx = AVS_ADDRESS[7:2];

  // ========================================================================
  // Next state
  always_comb begin
    n        = s;
    hit      = 1'b0;
    rd_val   = '0;
    wr_en    = 1'b0;
    pop      = 1'b0;
    rate_m1  = 2'h0;
    // Synchronisers for pins from outside the clock domain
    n.clk_sync = {s.clk_sync[1:0], OUTPUT_CLOCK_PIN};
    n.pd_sync  = {s.pd_sync[1:0], TX_POWERDOWN_PIN};
    n.dat_s1   = TX_BUS_IN;
    n.dat_s2   = s.dat_s1;
    clk_rise = s.clk_sync[1] & ~s.clk_sync[2];
    clk_fall = ~s.clk_sync[1] & s.clk_sync[2];
    pd_fall  = ~s.pd_sync[1] & s.pd_sync[2];
    loop     = s.cfg.mode[MODE_LOOP_BIT];
    full     = (s.count == 2'h2);

    // Register read mux and address decode
    if (AVS_ADDRESS[1:0] == 2'h0) begin
      hit = 1'b1;
      case (idx)
        IDX_GAIN: rd_val[7:0] = s.cfg.gain;
        IDX_UPD:  rd_val[7:0] = s.cfg.upd;
        IDX_FMT:  rd_val[7:0] = s.cfg.fmt;
        IDX_MODE: rd_val[7:0] = s.cfg.mode;
        IDX_STAT: begin
          rd_val[STAT_OVF_BIT] = s.ovf;
          rd_val[1]            = s.cfg.upd[UPD_SYNC_BIT] & (s.target != s.cfg.gain);
          rd_val[2]            = full;
          rd_val[5:4]          = s.mode;
          rd_val[15:8]         = s.applied;
          rd_val[23:16]        = s.target;
        end
        default: hit = 1'b0;
      endcase
    end

    // Bus answer: one wait cycle, then the request is taken
    case (s.bus)
      BUS_IDLE: begin
        if (AVS_READ | AVS_WRITE) begin
          n.bus   = BUS_ACK;
          n.rdata = AVS_READ ? rd_val : '0;
          n.resp  = hit ? RESP_OKAY : RESP_DECERR;
        end
      end
      BUS_ACK: begin
        n.bus = BUS_IDLE;
        wr_en = AVS_WRITE & AVS_BYTEENABLE[0] & hit;
      end
      default: n.bus = BUS_IDLE;
    endcase

    // Register writes
    if (wr_en) begin
      case (idx)
        IDX_GAIN: n.cfg.gain = AVS_WRITEDATA[7:0]; // R1
        IDX_UPD:  n.cfg.upd  = AVS_WRITEDATA[7:0] & UPD_MASK;
        IDX_FMT:  n.cfg.fmt  = AVS_WRITEDATA[7:0] & FMT_MASK;
        IDX_MODE: n.cfg.mode = AVS_WRITEDATA[7:0] & MODE_MASK;
        default: ;
      endcase
    end

    // Gain target: direct or held for the power-down wake-up
    if (!s.cfg.upd[UPD_SYNC_BIT]) begin
      n.target = n.cfg.gain; // R5
    end else if (pd_fall) begin
      n.target = s.cfg.gain; // R6
    end

    // Applied gain: jump when fast, else one step per cycle
    if (s.cfg.upd[UPD_FAST_BIT]) begin
      n.applied = s.target; // R7
    end else if (s.applied < s.target) begin
      n.applied = s.applied + 8'h01; // R7
    end else if (s.applied > s.target) begin
      n.applied = s.applied - 8'h01; // R7
    end

    // Transmit sampling on the selected output clock edge
    push    = s.cfg.fmt[FMT_INV_BIT] ? clk_fall : clk_rise; // R10
    push_ok = push & ~full;
    // Internal words are two's complement
    word = s.dat_s2;
    if (!s.cfg.fmt[FMT_TX2C_BIT]) begin
      word[SAMP_W-1] = ~s.dat_s2[SAMP_W-1]; // R8
    end

    // Overflow: a new sample with the buffer full; set wins over clear
    if (wr_en && idx == IDX_STAT && AVS_WRITEDATA[STAT_OVF_BIT]) begin
      n.ovf = 1'b0;
    end
    if (push && full) begin
      n.ovf = 1'b1;
    end

    // Interpolation: each word repeated 1, 2 or 4 times
    case (s.cfg.fmt[1:0])
      INTERP_2X: rate_m1 = 2'h1; // R11
      INTERP_4X: rate_m1 = 2'h3; // R11
      default:   rate_m1 = 2'h0; // R11
    endcase
    dn_ready = loop | TX_PATH_READY;
    if (!s.out_valid || dn_ready) begin
      if (s.rep != 2'h0) begin
        n.out_data  = s.hold;
        n.rep       = s.rep - 2'h1;
        n.out_valid = 1'b1;
      end else if (s.count != 2'h0) begin
        pop         = 1'b1;
        n.hold      = s.mem[s.rd_ptr];
        n.out_data  = s.mem[s.rd_ptr];
        n.rep       = rate_m1;
        n.out_valid = 1'b1;
      end else begin
        n.out_valid = 1'b0;
      end
    end

    // Two-entry buffer between sampler and interpolator
    if (push_ok) begin
      n.mem[s.wr_ptr] = word;
      n.wr_ptr        = ~s.wr_ptr;
    end
    if (pop) begin
      n.rd_ptr = ~s.rd_ptr;
    end
    n.count = s.count + {1'b0, push_ok} - {1'b0, pop};

    // Receive bus: loopback result or converter data
    n.rx_valid = 1'b0;
    if (loop) begin
      if (s.out_valid) begin
        n.rx_valid = 1'b1; // R12
        n.rx_data  = s.out_data;
        n.rx_data[SAMP_W-1] = s.out_data[SAMP_W-1] ^ ~s.cfg.fmt[FMT_RX2C_BIT]; // R9
      end
    end else if (RX_ADC_VALID) begin
      n.rx_valid = 1'b1;
      n.rx_data  = RX_ADC_IN;
      n.rx_data[SAMP_W-1] = RX_ADC_IN[SAMP_W-1] ^ s.cfg.fmt[FMT_RX2C_BIT]; // R9
    end

    // Interface mode
    if (s.cfg.mode[MODE_CLONE_BIT]) begin
      n.mode = CLONE_MODE; // R15
    end else if (s.cfg.mode[MODE_FULL_BIT] || loop) begin
      n.mode = FULL_DUPLEX_MODE; // R14 R12 R13
    end else if (s.cfg.mode[MODE_W10_BIT]) begin
      n.mode = HALF_DUPLEX_10BIT; // R16
    end else begin
      n.mode = HALF_DUPLEX_20BIT; // R16
    end
  end

  // ========================================================================
  // State register
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      s          <= '0;
      s.bus      <= BUS_IDLE;
      s.cfg.gain <= GAIN_RST; // R3
      s.cfg.upd  <= UPD_RST;
      s.cfg.fmt  <= FMT_RST;
      s.cfg.mode <= MODE_RST; // R14
      s.target   <= GAIN_RST;
      s.applied  <= GAIN_RST;
    end else begin
      s <= n;
    end
  end

  // ========================================================================
  // Outputs
  assign AVS_WAITREQUEST  = (s.bus != BUS_ACK);
  assign AVS_READDATA     = s.rdata;
  assign AVS_RESPONSE     = s.resp;
  assign TX_PATH_DATA     = s.out_data;
  assign TX_PATH_VALID    = s.out_valid & ~s.cfg.mode[MODE_LOOP_BIT];
  assign RX_BUS_OUT       = s.rx_data;
  assign RX_BUS_VALID     = s.rx_valid;
  assign TX_GAIN_AMP      = s.applied; // R1 R2 R4
  assign GAIN_FAST_SETTLE = s.cfg.upd[UPD_FAST_BIT];
  assign INTERP_RATE      = s.cfg.fmt[1:0];
  assign IF_MODE          = s.mode;
  assign LOOPBACK_ON      = s.cfg.mode[MODE_LOOP_BIT];

  // ========================================================================
  // Checks
  property p_gain_now;
    @(posedge REF_CLK) disable iff (!RST_B)
    (wr_en && idx == IDX_GAIN && !s.cfg.upd[UPD_SYNC_BIT])
      |=> (s.target == $past(AVS_WRITEDATA[7:0]));
  endproperty
  a_gain_now: assert property (p_gain_now) // R5
    else $error("gain target missed an immediate write");

  property p_gain_held;
    @(posedge REF_CLK) disable iff (!RST_B)
    (s.cfg.upd[UPD_SYNC_BIT] && !pd_fall) |=> $stable(s.target);
  endproperty
  a_gain_held: assert property (p_gain_held) // R6
    else $error("gain target moved without power-down wake-up");

  property p_gain_wake;
    @(posedge REF_CLK) disable iff (!RST_B)
    (s.cfg.upd[UPD_SYNC_BIT] && pd_fall) |=> (s.target == $past(s.cfg.gain));
  endproperty
  a_gain_wake: assert property (p_gain_wake) // R6
    else $error("gain not taken on power-down falling edge");

  property p_fast;
    @(posedge REF_CLK) disable iff (!RST_B)
    (s.cfg.upd[UPD_FAST_BIT] && s.applied != s.target)
      |=> (s.applied == $past(s.target));
  endproperty
  a_fast: assert property (p_fast) // R7
    else $error("fast gain did not settle in one cycle");

  property p_smooth;
    @(posedge REF_CLK) disable iff (!RST_B)
    (!s.cfg.upd[UPD_FAST_BIT] && s.applied < s.target)
      |=> (s.applied == $past(s.applied) + 8'h01);
  endproperty
  a_smooth: assert property (p_smooth) // R7
    else $error("smooth gain did not step by one");

  property p_duplex;
    @(posedge REF_CLK) disable iff (!RST_B)
    (!s.cfg.mode[MODE_CLONE_BIT] && !s.cfg.mode[MODE_LOOP_BIT])
      |=> (IF_MODE == ($past(s.cfg.mode[MODE_FULL_BIT]) ? FULL_DUPLEX_MODE
           : $past(s.cfg.mode[MODE_W10_BIT]) ? HALF_DUPLEX_10BIT : HALF_DUPLEX_20BIT));
  endproperty
  a_duplex: assert property (p_duplex) // R14
    else $error("interface mode does not follow duplex and width bits");

  property p_clone;
    @(posedge REF_CLK) disable iff (!RST_B)
    s.cfg.mode[MODE_CLONE_BIT] |=> (IF_MODE == CLONE_MODE);
  endproperty
  a_clone: assert property (p_clone) // R15
    else $error("duplex bit not ignored in clone mode");

  property p_sample;
    @(posedge REF_CLK) disable iff (!RST_B)
    (clk_rise && !s.cfg.fmt[FMT_INV_BIT] && s.count == 2'h0) |=> (s.count == 2'h1);
  endproperty
  a_sample: assert property (p_sample) // R10
    else $error("rising clock edge did not capture a word");

  property p_interp;
    @(posedge REF_CLK) disable iff (!RST_B)
    (pop && s.cfg.fmt[1:0] == INTERP_4X)
      |=> (s.out_valid && s.rep == 2'h3 && s.out_data == $past(s.mem[s.rd_ptr]));
  endproperty
  a_interp: assert property (p_interp) // R11
    else $error("four times interpolation not started");

  property p_loop;
    @(posedge REF_CLK) disable iff (!RST_B)
    (s.cfg.mode[MODE_LOOP_BIT] && s.out_valid) |=> RX_BUS_VALID;
  endproperty
  a_loop: assert property (p_loop) // R12
    else $error("loopback word missing on receive bus");

endmodule
`default_nettype wire

// ===== tgc_dsp_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// Far-side back end: drives link clock and transmit pins, takes path words
module tgc_dsp_model
  import tgc_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              slow,
  input  wire logic              stop,
  input  wire logic [SAMP_W-1:0] data,
  input  wire logic              valid,
  output logic                   link_clk,
  output logic      [SAMP_W-1:0] tx_bus,
  output logic                   ready
);
  logic [SAMP_W-1:0] got[$];
  logic [1:0]        cnt;

  // Idle link: clock stands low between words
  initial begin
    link_clk = 1'b0;
    tx_bus = '0;
    ready = 1'b0;
    cnt = '0;
  end

  // Receiver: logs words, stalls every other cycle when slow
  always @(posedge clk) begin
    if (valid && ready) begin
      got.push_back(data);
    end
    cnt <= cnt + 2'h1;
    ready <= !stop && (!slow || cnt[0]);
  end

  // One link period of 17 cycles; word stands only around the sampled edge
  task automatic send(input logic [SAMP_W-1:0] w, input logic fall);
    @(posedge clk);
    tx_bus <= fall ? ~w : w;
    repeat (4) @(posedge clk);
    link_clk <= 1'b1;
    repeat (4) @(posedge clk);
    tx_bus <= fall ? w : ~w;
    repeat (4) @(posedge clk);
    link_clk <= 1'b0;
    repeat (4) @(posedge clk);
    tx_bus <= fall ? ~w : w;
  endtask
endmodule
`default_nettype wire

// ===== tx_gain_and_io_config_regs_tb.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// Self-checking bench
module tx_gain_and_io_config_regs_tb
  import tgc_pkg::*;
;
  logic        ref_clk, rst_b, rd, wr, waitreq, link_clk, pd, adc_v;
  logic        p_valid, p_ready, rx_v, fast, loop_on, slow, stop;
  logic [7:0]  addr, gain_amp, q, f;
  logic [31:0] wdata, rdata, seed, x;
  logic [3:0]  be;
  logic [1:0]  resp, interp, if_mode, r;
  logic [9:0]  tx_bus, adc, p_data, rx_out, lb;
  logic [9:0]  expq[$];
  logic [7:0]  mtab[6] = '{8'h10, 8'h04, 8'h00, 8'h01, 8'h15, 8'h05};
  logic [1:0]  etab[6] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h3, 2'h3};
  int          fails, n_tests, k;

  tgc_regs dut_u (
    .REF_CLK(ref_clk), .RST_B(rst_b), .AVS_ADDRESS(addr), .AVS_READ(rd),
    .AVS_WRITE(wr), .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(be),
    .AVS_READDATA(rdata), .AVS_RESPONSE(resp), .AVS_WAITREQUEST(waitreq),
    .OUTPUT_CLOCK_PIN(link_clk), .TX_POWERDOWN_PIN(pd), .TX_BUS_IN(tx_bus),
    .RX_ADC_IN(adc), .RX_ADC_VALID(adc_v), .TX_PATH_DATA(p_data),
    .TX_PATH_VALID(p_valid), .TX_PATH_READY(p_ready), .RX_BUS_OUT(rx_out),
    .RX_BUS_VALID(rx_v), .TX_GAIN_AMP(gain_amp), .GAIN_FAST_SETTLE(fast),
    .INTERP_RATE(interp), .IF_MODE(if_mode), .LOOPBACK_ON(loop_on)
  );

  tgc_dsp_model dsp_u (
    .clk(ref_clk), .slow(slow), .stop(stop), .data(p_data), .valid(p_valid),
    .link_clk(link_clk), .tx_bus(tx_bus), .ready(p_ready)
  );

  // ========================================================================
  // Helpers
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic int reps(input logic [1:0] c);
    return (c == 2'h1) ? 2 : (c == 2'h2) ? 4 : 1;
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] e);
    n_tests++;
    if (seen !== e) begin
      fails++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, e);
    end
  endtask

  task automatic stop_test();
    if (fails == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Avalon transfer held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    rd <= !w;
    wr <= w;
    addr <= a;
    wdata <= {24'h0, d};
    // Only the watchdog ends a wait that never gets an answer
    do begin
      @(posedge ref_clk);
    end while (waitreq !== 1'b0);
    q = rdata[7:0];
    r = resp;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk({q, r}, {e, RESP_OKAY});
  endtask

  // Clock
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // Watchdog
  initial begin
    repeat (60000) @(posedge ref_clk);
    fails++;
    stop_test();
  end

  // ========================================================================
  // Main sequence
  initial begin
    {rst_b, rd, wr, adc_v, slow, stop, addr, wdata, adc} = '0;
    be = 4'hF;
    pd = 1'b1;
    seed = 32'hB18C9F86;
    repeat (12) @(posedge ref_clk);
    rst_b <= 1'b1;
    #1 chk(gain_amp, GAIN_RST);
    chk(if_mode, FULL_DUPLEX_MODE);
    rchk(8'h2C, GAIN_RST);
    rchk(8'h30, UPD_RST);
    rchk(8'h34, FMT_RST);
    rchk(8'h38, MODE_RST);
    // Unmapped and misaligned reads, masked write
    bus(1'b0, 8'h3C, 8'h00);
    chk({q, r}, {8'h00, RESP_DECERR});
    bus(1'b0, 8'h2D, 8'h00);
    chk(r, RESP_DECERR);
    be <= 4'h0;
    bus(1'b1, 8'h2C, 8'h00);
    be <= 4'hF;
    rchk(8'h2C, GAIN_RST);
    // Random write and read back
    for (int i = 0; i < 12; i++) begin
      x = rnd();
      f = (i % 4 == 0) ? 8'hFF : (i % 4 == 1) ? UPD_MASK : (i % 4 == 2) ? FMT_MASK : MODE_MASK;
      bus(1'b1, 8'(8'h2C + 4 * (i % 4)), x[7:0]);
      rchk(8'(8'h2C + 4 * (i % 4)), x[7:0] & f);
    end
    bus(1'b1, 8'h34, 8'h00);
    bus(1'b1, 8'h38, 8'h10);
    bus(1'b1, 8'h30, 8'h10);
    // Immediate fast gain
    for (int i = 0; i < 3; i++) begin
      x = rnd();
      bus(1'b1, 8'h2C, x[7:0]);
      repeat (3) @(posedge ref_clk);
      #1 chk(gain_amp, x[7:0]);
      chk(fast, 1'b1);
    end
    bus(1'b1, 8'h2C, 8'hFF);
    bus(1'b1, 8'h30, 8'h00);
    bus(1'b1, 8'h2C, 8'h00);
    repeat (8) @(posedge ref_clk);
    #1 chk(gain_amp > 8'hF0 && gain_amp < 8'hFF, 1);
    chk(fast, 1'b0);
    repeat (300) @(posedge ref_clk);
    #1 chk(gain_amp, 8'h00);
    // Gain held until power-down pin falls
    bus(1'b1, 8'h30, 8'h50);
    bus(1'b1, 8'h2C, 8'h5A);
    repeat (20) @(posedge ref_clk);
    #1 chk(gain_amp, 8'h00);
    @(posedge ref_clk);
    pd <= 1'b0;
    repeat (10) @(posedge ref_clk);
    #1 chk(gain_amp, 8'h5A);
    bus(1'b1, 8'h30, 8'h10);
    // Interface modes
    for (int i = 0; i < 6; i++) begin
      bus(1'b1, 8'h38, mtab[i]);
      repeat (2) @(posedge ref_clk);
      #1 chk(if_mode, etab[i]);
    end
    bus(1'b1, 8'h38, 8'h10);
    // Receive format
    for (int i = 0; i < 4; i++) begin
      x = rnd();
      bus(1'b1, 8'h34, {1'b0, x[10], 6'h00});
      @(posedge ref_clk);
      adc <= x[9:0];
      adc_v <= 1'b1;
      @(posedge ref_clk);
      adc_v <= 1'b0;
      #1 chk(rx_v, 1'b1);
      chk(rx_out, x[10] ? x[9:0] ^ 10'h200 : x[9:0]);
    end
    // Transmit stream over every format, edge and rate
    for (int i = 0; i < 16; i++) begin
      f = {i[0], 1'b0, i[1], 3'h0, i[3:2]};
      bus(1'b1, 8'h34, f);
      x = rnd();
      slow <= x[0];
      for (int j = 0; j < 3; j++) begin
        x = rnd();
        dsp_u.send(x[9:0], f[5]);
        repeat (reps(f[1:0])) expq.push_back(f[7] ? x[9:0] : x[9:0] ^ 10'h200);
      end
      repeat (40) @(posedge ref_clk);
      chk(dsp_u.got.size(), expq.size());
      chk(interp, f[1:0]);
      foreach (expq[n]) chk(dsp_u.got[n], expq[n]);
      expq.delete();
      dsp_u.got.delete();
    end
    // Buffer filled until a word is dropped, then overflow flag cleared
    bus(1'b1, 8'h34, 8'h00);
    stop <= 1'b1;
    repeat (5) dsp_u.send(10'h155, 1'b0);
    rchk(8'h40, 8'h05);
    bus(1'b1, 8'h40, 8'h01);
    rchk(8'h40, 8'h04);
    stop <= 1'b0;
    repeat (40) @(posedge ref_clk);
    dsp_u.got.delete();
    // Loopback with full duplex
    bus(1'b1, 8'h38, 8'h30);
    #1 chk({loop_on, if_mode}, {1'b1, FULL_DUPLEX_MODE});
    x = rnd();
    fork
      dsp_u.send(x[9:0], 1'b0);
      begin
        for (k = 0; k < 60 && rx_v !== 1'b1; k++) @(posedge ref_clk);
        lb = rx_out;
        chk(k < 60, 1'b1);
        chk(p_valid, 1'b0);
      end
    join
    chk(lb, x[9:0]);
    stop_test();
  end
endmodule
`default_nettype wire
